// ---- verilog/stp_translator.sv ----
// stepper translator, bridge gating and fault protection
//
// What this block does
// - Enable input high switches all bridge FETs off
// - Enable low lets regulation drive the FETs
// - Stepping continues regardless of enable level
// - Sleep low stops FETs, regulator, charge pump
// - Leaving sleep returns translator to home
// - Synchronous rectification during decay, off near zero
// - Overcurrent latches fault, outputs held off
// - Fault pin pulled low while latch set
// - Sleep, load undervoltage, optionally reset clear latch
// - Overtemperature or pump undervoltage disable, non-latched
// - Power-on lockout: outputs off, translator home
// - Full-torque modes drive nonzero windings at 100 percent
// - Common modes follow sine/cosine table
// - Code 001 is half step full torque
// - Code 101 is half step common table
// - Code 111 is eighth step, stride four
// - Each step rising edge advances one increment
// - Direction sampled at step edge, low forward
// - Resolution change applies at next step edge
// - Reset low holds home, outputs off, ignores steps
`timescale 1ns/10ps
module stp_translator #(
	parameter bit TRIP_CLR_ON_RESET = 1'b1
) (
	// clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	// host control inputs
	input  wire logic       step_i,
	input  wire logic       dir_i,
	input  wire logic [2:0] step_resolution_select_i,
	input  wire logic       outputs_disable_i,
	input  wire logic       sleep_n_i,
	input  wire logic       reset_n_i,
	// analog status
	input  wire logic       overcurrent_trip_i,
	input  wire logic       over_temp_i,
	input  wire logic       pump_supply_low_i,
	input  wire logic       undervoltage_lockout_i,
	// current regulator status per winding
	input  wire logic [1:0] pwm_off_i,
	input  wire logic [1:0] fast_decay_i,
	input  wire logic [1:0] near_zero_i,
	// winding current commands in percent
	output logic      [7:0] win1_pct_o,
	output logic      [7:0] win2_pct_o,
	// bridge gates {high a, low a, high b, low b}
	output logic      [3:0] gate1_o,
	output logic      [3:0] gate2_o,
	// power control
	output logic            pump_enable_o,
	output logic            regulator_enable_o,
	// open-drain fault pin
	output logic            fault_flag_n_o,
	output logic            fault_flag_n_oe_o,
	// status
	output logic [6:0]      position_o
);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [stp_pkg::SYNC_W-1:0] sync1_reg;
	logic [stp_pkg::SYNC_W-1:0] sync2_reg;
	logic                       step_prev_reg;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			sync1_reg     <= stp_pkg::SYNC_RESET;
			sync2_reg     <= stp_pkg::SYNC_RESET;
			step_prev_reg <= 1'b0;
		end else begin
			sync1_reg     <= {step_i, dir_i, step_resolution_select_i,
			                  outputs_disable_i, sleep_n_i, reset_n_i};
			sync2_reg     <= sync1_reg;
			step_prev_reg <= sync2_reg[stp_pkg::SY_STEP];
		end
	end

	logic       step_rise;
	logic       dir_s;
	logic [2:0] mode_s;
	logic       dis_s;
	logic       sleep_s;
	logic       resetn_s;

	assign step_rise = sync2_reg[stp_pkg::SY_STEP] & ~step_prev_reg;
	assign dir_s     = sync2_reg[stp_pkg::SY_DIR];
	assign mode_s    = sync2_reg[stp_pkg::SY_MS_HI:stp_pkg::SY_MS_LO];
	assign dis_s     = sync2_reg[stp_pkg::SY_DIS];
	assign sleep_s   = sync2_reg[stp_pkg::SY_SLEEP];
	assign resetn_s  = sync2_reg[stp_pkg::SY_RESET];

	// ----------------------------------------------------------------
	// operating state
	// ----------------------------------------------------------------
	stp_pkg::stp_state_t state_reg;
	stp_pkg::stp_state_t state_next;

	always_comb begin
		state_next = stp_pkg::ST_RUN;
		if (undervoltage_lockout_i) begin
			state_next = stp_pkg::ST_LOCKOUT;
		end else if (!sleep_s) begin
			state_next = stp_pkg::ST_ASLEEP;
		end else if (!resetn_s) begin
			state_next = stp_pkg::ST_HELD;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_reg <= stp_pkg::ST_LOCKOUT;
		end else begin
			state_reg <= state_next;
		end
	end

	logic run;
	assign run = (state_reg == stp_pkg::ST_RUN);

	// ----------------------------------------------------------------
	// translator position
	// ----------------------------------------------------------------
	function automatic logic [6:0] stride(input logic [2:0] m);
		logic [6:0] s;
		s = stp_pkg::STRIDE_1;
		unique case (m)
			stp_pkg::MODE_THIRTYSECOND: s = stp_pkg::STRIDE_32;
			stp_pkg::MODE_SIXTEENTH:    s = stp_pkg::STRIDE_16;
			stp_pkg::MODE_EIGHTH:       s = stp_pkg::STRIDE_8;
			stp_pkg::MODE_QUARTER:      s = stp_pkg::STRIDE_4;
			stp_pkg::MODE_HALF_100,
			stp_pkg::MODE_HALF_70:      s = stp_pkg::STRIDE_2;
			stp_pkg::MODE_FULL_100,
			stp_pkg::MODE_FULL_70:      s = stp_pkg::STRIDE_1;
		endcase
		return s;
	endfunction

	function automatic logic full_torque(input logic [2:0] m);
		return (m == stp_pkg::MODE_FULL_100) || (m == stp_pkg::MODE_HALF_100);
	endfunction

	logic [6:0] pos_reg;
	logic [2:0] mode_reg;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pos_reg <= stp_pkg::POS_HOME;
		end else if (!run) begin
			pos_reg <= stp_pkg::POS_HOME;
		end else if (step_rise) begin
			if (!dir_s) begin
				pos_reg <= pos_reg + stride(mode_s);
			end else begin
				pos_reg <= pos_reg - stride(mode_s);
			end
		end
	end

	// mode is taken only with a step edge once running
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			mode_reg <= stp_pkg::MODE_RESET;
		end else if (!run || step_rise) begin
			mode_reg <= mode_s;
		end
	end

	// ----------------------------------------------------------------
	// winding current table
	// ----------------------------------------------------------------
	logic [6:0] rise_mag;
	logic [6:0] fall_mag;

	stp_sine_lut u_lut (
		.offset_i (pos_reg[4:0]),
		.rise_o   (rise_mag),
		.fall_o   (fall_mag)
	);

	logic [6:0] mag1;
	logic [6:0] mag2;
	logic       neg1;
	logic       neg2;
	logic [7:0] pct1_next;
	logic [7:0] pct2_next;

	always_comb begin
		unique case (pos_reg[6:5])
			2'h0: begin
				mag1 = fall_mag;
				mag2 = rise_mag;
				neg1 = 1'b0;
				neg2 = 1'b0;
			end
			2'h1: begin
				mag1 = rise_mag;
				mag2 = fall_mag;
				neg1 = 1'b1;
				neg2 = 1'b0;
			end
			2'h2: begin
				mag1 = fall_mag;
				mag2 = rise_mag;
				neg1 = 1'b1;
				neg2 = 1'b1;
			end
			2'h3: begin
				mag1 = rise_mag;
				mag2 = fall_mag;
				neg1 = 1'b0;
				neg2 = 1'b1;
			end
		endcase
		if (full_torque(mode_reg)) begin
			if (mag1 != 7'h00) begin
				mag1 = stp_pkg::FULL_PCT[6:0];
			end
			if (mag2 != 7'h00) begin
				mag2 = stp_pkg::FULL_PCT[6:0];
			end
		end
		pct1_next = neg1 ? 8'h00 - {1'b0, mag1} : {1'b0, mag1};
		pct2_next = neg2 ? 8'h00 - {1'b0, mag2} : {1'b0, mag2};
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			win1_pct_o <= 8'h00;
			win2_pct_o <= 8'h00;
		end else begin
			win1_pct_o <= pct1_next;
			win2_pct_o <= pct2_next;
		end
	end

	assign position_o = pos_reg;

	// ----------------------------------------------------------------
	// overcurrent latch
	// ----------------------------------------------------------------
	logic trip_latch_reg;
	logic trip_clear;

	assign trip_clear = !sleep_s || undervoltage_lockout_i
	                    || (TRIP_CLR_ON_RESET && !resetn_s);

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			trip_latch_reg <= 1'b0;
		end else if (overcurrent_trip_i) begin
			trip_latch_reg <= 1'b1;
		end else if (trip_clear) begin
			trip_latch_reg <= 1'b0;
		end
	end

	assign fault_flag_n_o    = 1'b0;
	assign fault_flag_n_oe_o = trip_latch_reg;

	// ----------------------------------------------------------------
	// bridge gating and power control
	// ----------------------------------------------------------------
	logic drive_ok;
	assign drive_ok = run && !dis_s && !trip_latch_reg && !over_temp_i && !pump_supply_low_i;

	logic [7:0] pct_w  [2];
	logic [3:0] gate_w [2];
	assign pct_w[0] = win1_pct_o;
	assign pct_w[1] = win2_pct_o;

	for (genvar w = 0; w < 2; w++) begin : g_bridge
		logic [3:0] pat;
		logic [3:0] gate_reg;
		always_comb begin
			pat = stp_pkg::GATE_OFF;
			if (!pwm_off_i[w]) begin
				if (pct_w[w] != 8'h00) begin
					pat = pct_w[w][7] ? stp_pkg::GATE_NEG : stp_pkg::GATE_POS;
				end
			end else if (!near_zero_i[w]) begin
				if (fast_decay_i[w]) begin
					pat = pct_w[w][7] ? stp_pkg::GATE_POS : stp_pkg::GATE_NEG;
				end else begin
					pat = stp_pkg::GATE_LOWS;
				end
			end
		end
		always_ff @(posedge sys_clk_i) begin
			if (rst_i) begin
				gate_reg <= stp_pkg::GATE_OFF;
			end else begin
				gate_reg <= drive_ok ? pat : stp_pkg::GATE_OFF;
			end
		end
		assign gate_w[w] = gate_reg;
	end

	assign gate1_o = gate_w[0];
	assign gate2_o = gate_w[1];

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pump_enable_o      <= 1'b0;
			regulator_enable_o <= 1'b0;
		end else begin
			pump_enable_o      <= sleep_s && !undervoltage_lockout_i;
			regulator_enable_o <= sleep_s && !undervoltage_lockout_i;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	sequence step_taken_s;
		step_rise && run && state_next == stp_pkg::ST_RUN;
	endsequence

	sequence trip_s;
		overcurrent_trip_i ##1 !overcurrent_trip_i && !trip_clear;
	endsequence

	enable_off_a: assert property (dis_s |=> gate1_o == 4'h0 && gate2_o == 4'h0)
		else $error("bridge driven while outputs disabled");
	step_fwd_a: assert property ((step_taken_s and !dir_s) |=> pos_reg == 7'($past(pos_reg) + stride($past(mode_s))))
		else $error("forward step wrong increment");
	step_back_a: assert property ((step_taken_s and dir_s) |=> pos_reg == 7'($past(pos_reg) - stride($past(mode_s))))
		else $error("backward step wrong increment");
	disabled_step_a: assert property ((step_taken_s and dis_s) |=> pos_reg != $past(pos_reg))
		else $error("step lost while outputs disabled");
	sleep_power_a: assert property (!sleep_s |=> !pump_enable_o && !regulator_enable_o ##1 pos_reg == 7'h10)
		else $error("sleep left power on or not home");
	trip_hold_a: assert property (trip_s |-> trip_latch_reg && fault_flag_n_oe_o ##1 gate1_o == 4'h0)
		else $error("overcurrent not latched");
	trip_clear_a: assert property (trip_latch_reg && !sleep_s && !overcurrent_trip_i |=> !fault_flag_n_oe_o)
		else $error("sleep did not clear fault");
	therm_off_a: assert property ((over_temp_i || pump_supply_low_i) |=> gate2_o == 4'h0)
		else $error("bridge driven during thermal fault");
	reset_home_a: assert property (!resetn_s [*2] |=> pos_reg == 7'h10 && gate1_o == 4'h0)
		else $error("reset did not hold home");
	rect_zero_a: assert property (pwm_off_i[0] && near_zero_i[0] |=> gate1_o == 4'h0)
		else $error("rectification kept on near zero");
	eighth_a: assert property ((step_taken_s and !dir_s && mode_s == 3'h7) |=> pos_reg - $past(pos_reg) == 7'h04)
		else $error("eighth step stride wrong");

endmodule

// ---- common/stp_pkg.sv ----
// shared constants and types for the stepper translator and protection logic
package stp_pkg;

	// ----------------------------------------------------------------
	// position and translator
	// ----------------------------------------------------------------
	localparam int        POS_W      = 7;
	localparam logic [6:0] POS_HOME  = 7'h10;
	localparam logic [7:0] FULL_PCT  = 8'h64;

	// ----------------------------------------------------------------
	// resolution-select codes
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_FULL_100 = 3'h0;
	localparam logic [2:0] MODE_HALF_100 = 3'h1;
	localparam logic [2:0] MODE_SIXTEENTH = 3'h2;
	localparam logic [2:0] MODE_THIRTYSECOND = 3'h3;
	localparam logic [2:0] MODE_FULL_70  = 3'h4;
	localparam logic [2:0] MODE_HALF_70  = 3'h5;
	localparam logic [2:0] MODE_QUARTER  = 3'h6;
	localparam logic [2:0] MODE_EIGHTH   = 3'h7;
	localparam logic [2:0] MODE_RESET    = 3'h0;

	// ----------------------------------------------------------------
	// strides in finest positions
	// ----------------------------------------------------------------
	localparam logic [6:0] STRIDE_32  = 7'h01;
	localparam logic [6:0] STRIDE_16  = 7'h02;
	localparam logic [6:0] STRIDE_8   = 7'h04;
	localparam logic [6:0] STRIDE_4   = 7'h08;
	localparam logic [6:0] STRIDE_2   = 7'h10;
	localparam logic [6:0] STRIDE_1   = 7'h20;

	// ----------------------------------------------------------------
	// bridge gate patterns {high a, low a, high b, low b}
	// ----------------------------------------------------------------
	localparam logic [3:0] GATE_OFF    = 4'h0;
	localparam logic [3:0] GATE_POS    = 4'h9;
	localparam logic [3:0] GATE_NEG    = 4'h6;
	localparam logic [3:0] GATE_LOWS   = 4'h5;

	// ----------------------------------------------------------------
	// synchroniser layout and reset values
	// ----------------------------------------------------------------
	localparam int         SYNC_W     = 8;
	localparam logic [7:0] SYNC_RESET = 8'h00;
	localparam int         SY_STEP    = 7;
	localparam int         SY_DIR     = 6;
	localparam int         SY_MS_HI   = 5;
	localparam int         SY_MS_LO   = 3;
	localparam int         SY_DIS     = 2;
	localparam int         SY_SLEEP   = 1;
	localparam int         SY_RESET   = 0;

	typedef enum logic [1:0] {
		ST_LOCKOUT,
		ST_ASLEEP,
		ST_HELD,
		ST_RUN
	} stp_state_t;

endpackage

// ---- verilog/stp_sine_lut.sv ----
// quarter-wave winding current magnitudes for one quadrant offset
`timescale 1ns/10ps
module stp_sine_lut (
	// quadrant offset
	input  wire logic [4:0] offset_i,
	// magnitudes in percent
	output logic      [6:0] rise_o,
	output logic      [6:0] fall_o
);

	// ----------------------------------------------------------------
	// magnitude of the component rising from zero
	// ----------------------------------------------------------------
	function automatic logic [6:0] rise_val(input logic [5:0] j);
		logic [6:0] v;
		v = 7'h00;
		unique case (j)
			6'h00: v = 7'h00;
			6'h01: v = 7'h05;
			6'h02: v = 7'h0A;
			6'h03: v = 7'h0F;
			6'h04: v = 7'h14;
			6'h05: v = 7'h18;
			6'h06: v = 7'h1D;
			6'h07: v = 7'h22;
			6'h08: v = 7'h26;
			6'h09: v = 7'h2B;
			6'h0A: v = 7'h2F;
			6'h0B: v = 7'h33;
			6'h0C: v = 7'h38;
			6'h0D: v = 7'h3C;
			6'h0E: v = 7'h3F;
			6'h0F: v = 7'h43;
			6'h10: v = 7'h47;
			6'h11: v = 7'h4A;
			6'h12: v = 7'h4D;
			6'h13: v = 7'h50;
			6'h14: v = 7'h53;
			6'h15: v = 7'h56;
			6'h16: v = 7'h58;
			6'h17: v = 7'h5A;
			6'h18: v = 7'h5C;
			6'h19: v = 7'h5E;
			6'h1A: v = 7'h60;
			6'h1B: v = 7'h61;
			6'h1C: v = 7'h62;
			6'h1D: v = 7'h63;
			6'h1E, 6'h1F, 6'h20: v = 7'h64;
			default: v = 7'h00;
		endcase
		return v;
	endfunction

	logic [5:0] mirror;

	// the falling component is one percent lower at two table points
	always_comb begin
		mirror = 6'h20 - {1'b0, offset_i};
		rise_o = rise_val({1'b0, offset_i});
		fall_o = rise_val(mirror);
		if (mirror == 6'h04 || mirror == 6'h0C) begin
			fall_o = rise_val(mirror) - 7'h01;
		end
	end

endmodule

// ---- verif/stp_host_model.sv ----
// host controller model issuing step, direction and resolution requests
`timescale 1ns/10ps
module stp_host_model #(
	parameter int WAKE_CYC = 100000
) (
	// clock
	input  wire logic       clk_i,
	// host pins
	output logic            step_o,
	output logic            dir_o,
	output logic [2:0]      mode_o
);
	initial begin
		step_o = 1'b0;
		dir_o = 1'b0;
		mode_o = 3'h7;
	end

	// dir and mode settle two cycles before the rising edge
	task automatic pulse(input logic d, input logic [2:0] m);
		@(negedge clk_i);
		dir_o = d;
		mode_o = m;
		repeat (2) @(negedge clk_i);
		step_o = 1'b1;
		repeat (2) @(negedge clk_i);
		step_o = 1'b0;
		repeat (3) @(negedge clk_i);
	endtask

	// pump settling pause after leaving sleep
	task automatic wake_wait;
		repeat (WAKE_CYC) @(negedge clk_i);
	endtask
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the stepper translator and protection logic
`timescale 1ns/10ps
module testbench;
	logic        sys_clk_i = 1'b0;
	logic        rst_i     = 1'b1;
	logic        step, dir;
	logic [2:0]  ms;
	logic        dis = 1'b0, slp_n = 1'b1, rst_n = 1'b1;
	logic        trip = 1'b0, ot = 1'b0, pl = 1'b0, uv = 1'b0;
	logic [1:0]  off = 2'h0, fast = 2'h0, nz = 2'h0;
	logic [7:0]  w1, w2;
	logic [3:0]  g1, g2;
	logic        pump, rg, fl, fl_oe;
	wire         fault_pin = fl_oe ? fl : 1'b1;
	logic [6:0]  pos;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          e_pos = 16;
	logic [2:0]  e_mode = 3'h7;
	logic [31:0] lfsr = 32'h4E228073;
	int cq [0:32] = '{100, 100, 100, 99, 98, 97, 96, 94, 92, 90, 88, 86, 83, 80, 77, 74, 71,
		67, 63, 60, 55, 51, 47, 43, 38, 34, 29, 24, 19, 15, 10, 5, 0};
	// rising winding magnitude within a quadrant, not a plain mirror of cq
	int sq [0:32] = '{0, 5, 10, 15, 20, 24, 29, 34, 38, 43, 47, 51, 56, 60, 63, 67, 71,
		74, 77, 80, 83, 86, 88, 90, 92, 94, 96, 97, 98, 99, 100, 100, 100};

	always #5 sys_clk_i = ~sys_clk_i;

	// shortened pump pause keeps the run brief
	stp_host_model #(.WAKE_CYC(200)) host (.clk_i(sys_clk_i), .step_o(step), .dir_o(dir), .mode_o(ms));

	stp_translator dut (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .step_i(step), .dir_i(dir),
		.step_resolution_select_i(ms), .outputs_disable_i(dis), .sleep_n_i(slp_n),
		.reset_n_i(rst_n), .overcurrent_trip_i(trip), .over_temp_i(ot),
		.pump_supply_low_i(pl), .undervoltage_lockout_i(uv), .pwm_off_i(off),
		.fast_decay_i(fast), .near_zero_i(nz), .win1_pct_o(w1), .win2_pct_o(w2),
		.gate1_o(g1), .gate2_o(g2), .pump_enable_o(pump), .regulator_enable_o(rg),
		.fault_flag_n_o(fl), .fault_flag_n_oe_o(fl_oe), .position_o(pos));

	// ----------------------------------------------------------------
	// reference model
	// ----------------------------------------------------------------
	function automatic int stride(input logic [2:0] m);
		case (m)
			3'h0, 3'h4: return 32;
			3'h1, 3'h5: return 16;
			3'h6: return 8;
			3'h7: return 4;
			3'h2: return 2;
			default: return 1;
		endcase
	endfunction

	function automatic logic [7:0] cosv(input int p, input logic [2:0] m);
		int v;
		v = ((p / 32) % 2) ? sq[p % 32] : cq[p % 32];
		if (m < 3'h2 && v != 0) v = 100;
		if (p / 32 == 1 || p / 32 == 2) v = -v;
		return v[7:0];
	endfunction

	function automatic logic [7:0] eg(input logic [7:0] p, input logic o, input logic f, input logic z);
		if (o) return z ? 8'h00 : (f ? (p[7] ? 8'h09 : 8'h06) : 8'h05);
		return (p == 8'h00) ? 8'h00 : (p[7] ? 8'h06 : 8'h09);
	endfunction

	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask

	// ----------------------------------------------------------------
	// stimulus helpers
	// ----------------------------------------------------------------
	task automatic stp(input logic d, input logic [2:0] m, input bit run);
		host.pulse(d, m);
		if (run) begin
			e_pos = (e_pos + (d ? 128 - stride(m) : stride(m))) % 128;
			e_mode = m;
			check("win1", w1, cosv(e_pos, e_mode));
			check("win2", w2, cosv((e_pos + 96) % 128, e_mode));
		end
		check("position", {1'b0, pos}, e_pos[7:0]);
	endtask

	task automatic gchk(input logic [1:0] o, input logic [1:0] f, input logic [1:0] z, input bit on);
		@(negedge sys_clk_i);
		off = o;
		fast = f;
		nz = z;
		wt(2);
		check("gate1", {4'h0, g1}, on ? eg(cosv(e_pos, e_mode), o[0], f[0], z[0]) : 8'h00);
		check("gate2", {4'h0, g2}, on ? eg(cosv((e_pos + 96) % 128, e_mode), o[1], f[1], z[1]) : 8'h00);
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#50000;
		n_mismatch++;
		summarize;
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		rst_i = 1'b0;
		host.wake_wait;
		check("home position", {1'b0, pos}, 8'h10);
		check("home win1", w1, cosv(16, 3'h7));
		check("home win2", w2, cosv(112, 3'h7));
		for (int i = 0; i < 8; i++)
			stp(1'b0, i[2:0], 1'b1);
		for (int i = 0; i < 30; i++) begin
			lfsr = lfsr_next(lfsr);
			stp(lfsr[0], lfsr[3:1], 1'b1);
		end
		rst_n = 1'b0;
		e_pos = 16;
		wt(4);
		stp(1'b0, e_mode, 1'b0);
		gchk(2'h0, 2'h0, 2'h0, 1'b0);
		rst_n = 1'b1;
		wt(4);
		gchk(2'h0, 2'h0, 2'h0, 1'b1);
		gchk(2'h3, 2'h0, 2'h0, 1'b1);
		gchk(2'h3, 2'h3, 2'h0, 1'b1);
		gchk(2'h3, 2'h1, 2'h2, 1'b1);
		dis = 1'b1;
		wt(4);
		gchk(2'h0, 2'h0, 2'h0, 1'b0);
		stp(1'b0, 3'h7, 1'b1);
		dis = 1'b0;
		wt(4);
		gchk(2'h0, 2'h0, 2'h0, 1'b1);
		for (int i = 1; i < 3; i++) begin
			{ot, pl} = i[1:0];
			gchk(2'h0, 2'h0, 2'h0, 1'b0);
			{ot, pl} = 2'h0;
			gchk(2'h0, 2'h0, 2'h0, 1'b1);
		end
		trip = 1'b1;
		wt(1);
		trip = 1'b0;
		wt(2);
		check("fault pin", {7'h0, fault_pin}, 8'h00);
		gchk(2'h0, 2'h0, 2'h0, 1'b0);
		slp_n = 1'b0;
		e_pos = 16;
		wt(5);
		check("fault pin", {7'h0, fault_pin}, 8'h01);
		check("pump", {6'h0, pump, rg}, 8'h00);
		check("position", {1'b0, pos}, 8'h10);
		gchk(2'h0, 2'h0, 2'h0, 1'b0);
		slp_n = 1'b1;
		host.wake_wait;
		check("pump", {6'h0, pump, rg}, 8'h03);
		stp(1'b1, 3'h6, 1'b1);
		trip = 1'b1;
		wt(1);
		trip = 1'b0;
		uv = 1'b1;
		e_pos = 16;
		wt(3);
		check("position", {1'b0, pos}, 8'h10);
		gchk(2'h0, 2'h0, 2'h0, 1'b0);
		uv = 1'b0;
		wt(5);
		check("fault pin", {7'h0, fault_pin}, 8'h01);
		gchk(2'h0, 2'h0, 2'h0, 1'b1);
		// full step to 135 degrees puts negative current on winding 1
		stp(1'b0, 3'h0, 1'b1);
		gchk(2'h0, 2'h0, 2'h0, 1'b1);
		gchk(2'h3, 2'h3, 2'h0, 1'b1);
		summarize;
	end
endmodule
